//--- hdl/smi_dir_regs.sv
// apb register slice: serial direction options and management interrupt status
// Function
// [R01] option bit 0 turns automatic direction control on for port a
// [R02] option bit 1 steers port a control to request-to-send, else terminal-ready
// [R03] option bit 2 sets port a polarity: 0 drives low, 1 drives high
// [R04] bits 4 to 6 repeat the controls for port b; bits 3, 7 reserved
// [R05] second option register holds the same layout for ports c and d
// [R06] status one bit 0 is the battery low flag, write one clears
// [R07] standby reset sets battery flag on battery swap or battery-only drop
// [R08] main-power reset sets battery flag if battery fell below higher threshold
// [R09] status one resets to 0x03 after a battery event, else 0x02
// [R10] parallel bit reads 1 while port idle, else follows acknowledge input
// [R11] every reset kind forces the parallel bit to 1
// [R12] status one bits 1-4 and 7 are read-only source conditions
// [R13] status two bits 0, 1 mirror mouse and keyboard conditions
// [R14] infrared pin transition sets status two bit 2; reading clears it
// [R15] status two bit 4 flags mouse click wake, write one clears
// [R16] status three bits 1-7 hold gpio events, write one clears
// [R17] status four holds uart c-f and four gpio events, write one clears
// [R18] status two to four reset to zero on standby reset
// [R19] each source feeds the combined interrupt only when enabled
// [R20] combined interrupt reaches the pin only with enable two bit 7
// [R21] writing zero or to read-only bits changes nothing; reserved reads zero
// [R22] a source event beats a clear in the same cycle
//
// Local design decision: the APB register port.
module smi_dir_regs
  import smi_regs_pkg::*;
#(
  parameter int ADDR_W    = 8,
  parameter int NUM_PORTS = 4
)(
  // clock and standby-power reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // other reset kinds and battery state
  input  wire logic              main_power_reset,
  input  wire logic              bus_reset,
  input  wire logic              soft_reset,
  input  wire logic              battery_swapped,
  input  wire logic              battery_below_standby,
  input  wire logic              battery_below_main,
  // interrupt sources
  input  wire logic              parallel_port_active,
  input  wire logic              printer_acknowledge_input,
  input  wire logic              uart_a_irq,
  input  wire logic              uart_b_irq,
  input  wire logic              floppy_irq,
  input  wire logic              watchdog_event,
  input  wire logic              mouse_irq,
  input  wire logic              keyboard_irq,
  input  wire logic              infrared_receive_pin,
  input  wire logic              mouse_click_wake,
  input  wire logic [3:0]        uart_cdef_irq,
  input  wire logic [10:0]       gpio_event,
  // direction control per port
  input  wire logic [NUM_PORTS-1:0] tx_active,
  output logic      [NUM_PORTS-1:0] request_to_send_line_steer,
  output logic      [NUM_PORTS-1:0] terminal_ready_line_steer,
  output logic      [NUM_PORTS-1:0] steer_level,
  // combined interrupt
  output logic                   mgmt_irq_group,
  output logic                   mgmt_interrupt_pin_n
);

  initial
  begin
    if (NUM_PORTS != 4 || ADDR_W < 7 || ADDR_W > 32)
      $error("smi_dir_regs: unsupported NUM_PORTS or ADDR_W");
  end

  // ************************************************************
  // address decode
  // ************************************************************
  localparam logic [ADDR_W-1:0] A_OPT_AB = ADDR_W'({OPT_AB_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_OPT_CD = ADDR_W'({OPT_CD_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_STS1   = ADDR_W'({STS1_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_STS2   = ADDR_W'({STS2_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_STS3   = ADDR_W'({STS3_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_STS4   = ADDR_W'({STS4_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_EN1    = ADDR_W'({EN1_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_EN2    = ADDR_W'({EN2_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_EN3    = ADDR_W'({EN3_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_EN4    = ADDR_W'({EN4_IDX, 2'b00});

  logic [7:0] opt_ab_reg;
  logic [7:0] opt_cd_reg;
  logic [7:0] en1_reg;
  logic [7:0] en2_reg;
  logic [7:0] en3_reg;
  logic [7:0] en4_reg;
  logic       batt_flag_reg;
  logic       par_flag_reg;
  logic [7:0] live1_reg;
  logic [7:0] live2_reg;
  logic       ir_flag_reg;
  logic       ir_prev_reg;
  logic       click_flag_reg;
  logic [7:0] sts3_reg;
  logic [7:0] sts4_reg;
  logic       init_done_reg;
  logic [7:0] rd_byte_reg;
  logic [7:0] sts1_val;
  logic [7:0] sts2_val;
  logic [7:0] rd_mux;
  logic       addr_hit;
  logic       setup_ph;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] wbyte;
  logic       ir_edge;
  logic [7:0] sts3_set;
  logic [7:0] sts4_set;
  logic       batt_set;
  logic       group_next;

  assign setup_ph = psel && !penable;
  // lane 0 only: upper byte lanes carry no register bits
  assign wr_done  = psel && penable && pready && pwrite && pstrb[0];
  assign rd_done  = psel && penable && pready && !pwrite;
  assign wbyte    = pwdata[7:0];

  // ************************************************************
  // status composition
  // ************************************************************
  always_comb
  begin
    sts1_val = live1_reg & STS1_MASK;                                   // [R12]
    sts1_val[STS1_BATT_BIT] = batt_flag_reg;                            // [R06]
    sts1_val[STS1_PAR_BIT]  = par_flag_reg;
    sts2_val = live2_reg & STS2_MASK;                                   // [R13]
    sts2_val[STS2_IR_BIT]    = ir_flag_reg;
    sts2_val[STS2_CLICK_BIT] = click_flag_reg;
  end

  always_comb
  begin
    rd_mux   = ZERO_BYTE;
    addr_hit = 1'b1;
    unique case (paddr)
      A_OPT_AB: rd_mux = opt_ab_reg;
      A_OPT_CD: rd_mux = opt_cd_reg;
      A_STS1:   rd_mux = sts1_val;
      A_STS2:   rd_mux = sts2_val;
      A_STS3:   rd_mux = sts3_reg;
      A_STS4:   rd_mux = sts4_reg;
      A_EN1:    rd_mux = en1_reg;
      A_EN2:    rd_mux = en2_reg;
      A_EN3:    rd_mux = en3_reg;
      A_EN4:    rd_mux = en4_reg;
      default:  addr_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // apb answer: data sampled in setup, one access cycle
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      rd_byte_reg <= ZERO_BYTE;
    end
    else
    begin
      pready <= setup_ph;
      if (setup_ph)
      begin
        pslverr     <= !addr_hit;
        prdata      <= {24'h00_0000, rd_mux};
        rd_byte_reg <= rd_mux;
      end
      else if (pready)
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // ************************************************************
  // option and enable registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_ab_reg <= OPT_RESET;
      opt_cd_reg <= OPT_RESET;
    end
    else if (wr_done)
    begin
      if (paddr == A_OPT_AB)
        opt_ab_reg <= wbyte & OPT_MASK;                                 // [R04]
      if (paddr == A_OPT_CD)
        opt_cd_reg <= wbyte & OPT_MASK;                                 // [R05]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en1_reg <= ZERO_BYTE;
      en2_reg <= ZERO_BYTE;
      en3_reg <= ZERO_BYTE;
      en4_reg <= ZERO_BYTE;
    end
    else if (wr_done)
    begin
      if (paddr == A_EN1)
        en1_reg <= wbyte & STS1_MASK;
      if (paddr == A_EN2)
        en2_reg <= wbyte & (STS2_MASK | (8'h01 << EN2_PIN_BIT));
      if (paddr == A_EN3)
        en3_reg <= wbyte & STS3_MASK;
      if (paddr == A_EN4)
        en4_reg <= wbyte;
    end
  end

  // ************************************************************
  // battery and parallel flags
  // ************************************************************
  // battery straps are caught on the first edge after standby reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      init_done_reg <= 1'b0;
    else
      init_done_reg <= 1'b1;
  end

  assign batt_set = (!init_done_reg && (battery_swapped || battery_below_standby)) // [R07]
                 || (main_power_reset && battery_below_main);           // [R08]

  localparam logic STS1_RESET_BATT = 1'b0;
  localparam logic STS1_RESET_PAR  = 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      batt_flag_reg <= STS1_RESET_BATT;                                 // [R09]
    else if (batt_set)
      batt_flag_reg <= 1'b1;                                            // [R22]
    else if (wr_done && paddr == A_STS1 && wbyte[STS1_BATT_BIT])
      batt_flag_reg <= 1'b0;                                            // [R06] [R21]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      par_flag_reg <= STS1_RESET_PAR;                                   // [R09] [R11]
    else if (main_power_reset || bus_reset || soft_reset)
      par_flag_reg <= 1'b1;                                             // [R11]
    else if (!parallel_port_active)
      par_flag_reg <= 1'b1;                                             // [R10]
    else
      par_flag_reg <= printer_acknowledge_input;                        // [R10]
  end

  // ************************************************************
  // read-only source mirrors
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      live1_reg <= ZERO_BYTE;
      live2_reg <= ZERO_BYTE;
    end
    else
    begin
      live1_reg <= ZERO_BYTE;
      live1_reg[STS1_UB_BIT]   <= uart_b_irq;                           // [R12]
      live1_reg[STS1_UA_BIT]   <= uart_a_irq;                           // [R12]
      live1_reg[STS1_FLOP_BIT] <= floppy_irq;                           // [R12]
      live1_reg[STS1_WDOG_BIT] <= watchdog_event;                       // [R12]
      live2_reg <= ZERO_BYTE;
      live2_reg[STS2_MOUSE_BIT] <= mouse_irq;                           // [R13]
      live2_reg[STS2_KBD_BIT]   <= keyboard_irq;                        // [R13]
    end
  end

  // ************************************************************
  // sticky event flags
  // ************************************************************
  // guarded by init so the reset value of the previous sample makes no edge
  assign ir_edge = init_done_reg && (infrared_receive_pin != ir_prev_reg);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ir_prev_reg <= 1'b0;
    else
      ir_prev_reg <= infrared_receive_pin;
  end

  // only a flag value that the read returned is cleared, so a late edge survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ir_flag_reg <= 1'b0;                                              // [R18]
    else if (ir_edge)
      ir_flag_reg <= 1'b1;                                              // [R14] [R22]
    else if (rd_done && paddr == A_STS2 && rd_byte_reg[STS2_IR_BIT])
      ir_flag_reg <= 1'b0;                                              // [R14]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      click_flag_reg <= 1'b0;                                           // [R18]
    else if (mouse_click_wake)
      click_flag_reg <= 1'b1;                                           // [R15] [R22]
    else if (wr_done && paddr == A_STS2 && wbyte[STS2_CLICK_BIT])
      click_flag_reg <= 1'b0;                                           // [R15] [R21]
  end

  assign sts3_set = {gpio_event[6:0], 1'b0};                           // [R16]
  assign sts4_set = {gpio_event[10], uart_cdef_irq[3], gpio_event[9], uart_cdef_irq[2],
                     gpio_event[8], gpio_event[7], uart_cdef_irq[1], uart_cdef_irq[0]}; // [R17]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts3_reg <= ZERO_BYTE;                                            // [R18]
      sts4_reg <= ZERO_BYTE;                                            // [R18]
    end
    else
    begin
      // set term ored last so it wins over a same-cycle clear
      sts3_reg <= ((wr_done && paddr == A_STS3) ? (sts3_reg & ~wbyte) : sts3_reg)
                  | sts3_set;                                           // [R16] [R22]
      sts4_reg <= ((wr_done && paddr == A_STS4) ? (sts4_reg & ~wbyte) : sts4_reg)
                  | sts4_set;                                           // [R17] [R22]
    end
  end

  // ************************************************************
  // combined interrupt
  // ************************************************************
  assign group_next = |(sts1_val & en1_reg) || |(sts2_val & en2_reg & STS2_MASK)
                   || |(sts3_reg & en3_reg) || |(sts4_reg & en4_reg);  // [R19]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mgmt_irq_group       <= 1'b0;
      mgmt_interrupt_pin_n <= 1'b1;
    end
    else
    begin
      mgmt_irq_group       <= group_next;
      mgmt_interrupt_pin_n <= !(group_next && en2_reg[EN2_PIN_BIT]);    // [R20]
    end
  end

  // ************************************************************
  // automatic direction control
  // ************************************************************
  logic [NUM_PORTS*PORT_STRIDE-1:0] opt_all;
  assign opt_all = {opt_cd_reg, opt_ab_reg};                            // [R05]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      request_to_send_line_steer <= '0;
      terminal_ready_line_steer  <= '0;
      steer_level                <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        request_to_send_line_steer[p] <= opt_all[p*PORT_STRIDE + OPT_ON_BIT]
                                      && opt_all[p*PORT_STRIDE + OPT_SEL_BIT];  // [R01] [R02] [R04]
        terminal_ready_line_steer[p]  <= opt_all[p*PORT_STRIDE + OPT_ON_BIT]
                                      && !opt_all[p*PORT_STRIDE + OPT_SEL_BIT]; // [R01] [R02] [R04]
        // idle level is the opposite of the active drive
        steer_level[p] <= tx_active[p] ? opt_all[p*PORT_STRIDE + OPT_POL_BIT]
                                       : !opt_all[p*PORT_STRIDE + OPT_POL_BIT]; // [R03]
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sts3_clear_with_event;
    wr_done && paddr == A_STS3 && wbyte[1] && gpio_event[0];
  endsequence

  sequence s_sts2_read_taken;
    setup_ph && !pwrite && paddr == A_STS2 && ir_flag_reg ##1 rd_done && !ir_edge;
  endsequence

  chk_opt_reserved_zero: assert property (!opt_ab_reg[3] && !opt_ab_reg[7]
    && !opt_cd_reg[3] && !opt_cd_reg[7])                                // [R04]
    else $error("reserved option bit set");
  chk_dir_off_idle: assert property (!opt_ab_reg[0] |=>
    !request_to_send_line_steer[0] && !terminal_ready_line_steer[0])    // [R01]
    else $error("port a steered while off");
  chk_dir_select: assert property (opt_cd_reg[4] && opt_cd_reg[5] |=>
    request_to_send_line_steer[3] && !terminal_ready_line_steer[3])     // [R02]
    else $error("port d line select wrong");
  chk_dir_polarity: assert property (tx_active[1] |=> steer_level[1] == $past(opt_ab_reg[6]))
    else $error("port b polarity wrong");                               // [R03]
  chk_batt_main_set: assert property (main_power_reset && battery_below_main
    |=> batt_flag_reg [*2])                                             // [R08]
    else $error("battery flag not set by main reset");
  chk_par_idle_one: assert property (!parallel_port_active |=> par_flag_reg)
    else $error("parallel bit not 1 while idle");                       // [R10]
  chk_par_follow_ack: assert property (parallel_port_active && !bus_reset && !soft_reset
    && !main_power_reset |=> par_flag_reg == $past(printer_acknowledge_input))
    else $error("parallel bit not following ack");                      // [R10]
  chk_par_reset_one: assert property (main_power_reset || bus_reset || soft_reset
    |=> par_flag_reg)                                                   // [R11]
    else $error("parallel bit not forced by reset");
  chk_ir_read_clear: assert property (s_sts2_read_taken |=> !ir_flag_reg)
    else $error("infrared flag not cleared by read");                   // [R14]
  chk_set_beats_clear: assert property (s_sts3_clear_with_event |=> sts3_reg[1])
    else $error("gpio event lost to clear");                            // [R22]
  chk_pin_gate: assert property (!en2_reg[EN2_PIN_BIT] |=> mgmt_interrupt_pin_n)
    else $error("interrupt pin driven while disabled");                 // [R20]
  chk_group_gate: assert property (en1_reg == ZERO_BYTE && en2_reg == ZERO_BYTE
    && en3_reg == ZERO_BYTE && en4_reg == ZERO_BYTE |=> !mgmt_irq_group)
    else $error("group interrupt without enable");                      // [R19]
  chk_status_init_zero: assert property (!init_done_reg |-> sts3_reg == ZERO_BYTE
    && sts4_reg == ZERO_BYTE && !ir_flag_reg && !click_flag_reg)        // [R18]
    else $error("status not zero after standby reset");

endmodule // smi_dir_regs

//--- pkg/smi_regs_pkg.sv
// register map, field layout and reset values of the direction and interrupt status slice
package smi_regs_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] OPT_AB_IDX = 8'h12;
  localparam logic [7:0] OPT_CD_IDX = 8'h13;
  localparam logic [7:0] STS1_IDX   = 8'h14;
  localparam logic [7:0] STS2_IDX   = 8'h15;
  localparam logic [7:0] STS3_IDX   = 8'h16;
  localparam logic [7:0] STS4_IDX   = 8'h17;
  localparam logic [7:0] EN1_IDX    = 8'h18;
  localparam logic [7:0] EN2_IDX    = 8'h19;
  localparam logic [7:0] EN3_IDX    = 8'h1A;
  localparam logic [7:0] EN4_IDX    = 8'h1B;

  // ************************************************************
  // option register layout
  // ************************************************************
  localparam int         PORT_STRIDE = 4;
  localparam int         OPT_ON_BIT  = 0;
  localparam int         OPT_SEL_BIT = 1;
  localparam int         OPT_POL_BIT = 2;
  localparam logic [7:0] OPT_MASK    = 8'h77;
  localparam logic [7:0] OPT_RESET   = 8'h44;

  // ************************************************************
  // status and enable layout
  // ************************************************************
  localparam int         STS1_BATT_BIT = 0;
  localparam int         STS1_PAR_BIT  = 1;
  localparam int         STS1_UB_BIT   = 2;
  localparam int         STS1_UA_BIT   = 3;
  localparam int         STS1_FLOP_BIT = 4;
  localparam int         STS1_WDOG_BIT = 7;
  localparam logic [7:0] STS1_MASK     = 8'h9F;
  localparam int         STS2_MOUSE_BIT = 0;
  localparam int         STS2_KBD_BIT   = 1;
  localparam int         STS2_IR_BIT    = 2;
  localparam int         STS2_CLICK_BIT = 4;
  localparam logic [7:0] STS2_MASK      = 8'h17;
  localparam logic [7:0] STS3_MASK      = 8'hFE;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
  localparam int         EN2_PIN_BIT    = 7;

endpackage : smi_regs_pkg

//--- tb/rs485_dir_and_smi_status_regs_tb_top.sv
// self-checking bench for the direction option and interrupt status slice
module rs485_dir_and_smi_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smi_regs_pkg::*;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF, uart_cdef_irq = 4'h0, tx_active = 4'h0;
  logic pready, pslverr, mgmt_irq_group, mgmt_interrupt_pin_n;
  logic main_power_reset = 0, battery_swapped = 1, battery_below_main = 0;
  logic bus_reset = 0, soft_reset = 0, par_active = 0, ack_in = 0;
  logic uart_a_irq = 0, uart_b_irq = 0, floppy_irq = 0, watchdog_event = 0;
  logic mouse_irq = 0, keyboard_irq = 0, infrared_receive_pin = 0, mouse_click_wake = 0;
  logic [10:0] gpio_event = 11'h000;
  logic [3:0] rts_steer, dtr_steer, steer_level;
  int mismatches = 0, tests_run = 0;
  logic [31:0] rd;
  logic err;
  initial forever #4 pclk = ~pclk;
  smi_dir_regs u_smi_dir_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_power_reset(main_power_reset), .bus_reset(bus_reset), .soft_reset(soft_reset),
    .battery_swapped(battery_swapped), .battery_below_standby(1'b0),
    .battery_below_main(battery_below_main), .parallel_port_active(par_active),
    .printer_acknowledge_input(ack_in), .uart_a_irq(uart_a_irq), .uart_b_irq(uart_b_irq),
    .floppy_irq(floppy_irq), .watchdog_event(watchdog_event), .mouse_irq(mouse_irq),
    .keyboard_irq(keyboard_irq), .infrared_receive_pin(infrared_receive_pin),
    .mouse_click_wake(mouse_click_wake), .uart_cdef_irq(uart_cdef_irq),
    .gpio_event(gpio_event), .tx_active(tx_active), .request_to_send_line_steer(rts_steer),
    .terminal_ready_line_steer(dtr_steer), .steer_level(steer_level),
    .mgmt_irq_group(mgmt_irq_group), .mgmt_interrupt_pin_n(mgmt_interrupt_pin_n));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0, 4'hF);
    chk({pslverr_seen(), rd}, {1'b0, e});
  endtask
  function automatic logic pslverr_seen();
    return err;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, 4'hF);
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd_chk(8'h48, 32'h44);
    rd_chk(8'h4C, 32'h44);
    rd_chk(8'h50, 32'h03);
    rd_chk(8'h54, 32'h00);
    rd_chk(8'h58, 32'h00);
    rd_chk(8'h5C, 32'h00);
  endtask
  task automatic t_options();
    wr(8'h48, 32'hFF);
    rd_chk(8'h48, 32'h77);
    apb(1, 8'h48, 32'h00, 4'hE);
    rd_chk(8'h48, 32'h77);
    wr(8'h48, 32'h07);
    wr(8'h4C, 32'h10);
    tx_active <= 4'b1001;
    settle();
    chk({rts_steer, dtr_steer}, 8'b0001_1000);
    chk(steer_level & 4'b1001, 4'b0001);
    tx_active <= 4'b0000;
  endtask
  task automatic t_battery();
    battery_swapped <= 0;
    wr(8'h50, 32'h01);
    rd_chk(8'h50, 32'h02);
    battery_below_main <= 1;
    @(posedge pclk);
    main_power_reset <= 1;
    @(posedge pclk);
    main_power_reset <= 0;
    battery_below_main <= 0;
    settle();
    rd_chk(8'h50, 32'h03);
    wr(8'h50, 32'h01);
  endtask
  task automatic t_parallel();
    par_active <= 1;
    settle();
    rd_chk(8'h50, 32'h00);
    ack_in <= 1;
    settle();
    rd_chk(8'h50, 32'h02);
    ack_in <= 0;
    bus_reset <= 1;
    @(posedge pclk);
    bus_reset <= 0;
    soft_reset <= 1;
    @(posedge pclk);
    soft_reset <= 0;
    settle();
    rd_chk(8'h50, 32'h00);
    par_active <= 0;
    settle();
  endtask
  task automatic t_sources();
    {uart_a_irq, uart_b_irq, floppy_irq, watchdog_event} <= 4'hF;
    {mouse_irq, keyboard_irq} <= 2'b11;
    settle();
    wr(8'h50, 32'hFE);
    rd_chk(8'h50, 32'h9E);
    wr(8'h54, 32'h03);
    rd_chk(8'h54, 32'h03);
    {uart_a_irq, uart_b_irq, floppy_irq, watchdog_event, mouse_irq, keyboard_irq} <= 6'h0;
    settle();
    rd_chk(8'h50, 32'h02);
  endtask
  task automatic t_infrared();
    infrared_receive_pin <= 1;
    settle();
    rd_chk(8'h54, 32'h04);
    rd_chk(8'h54, 32'h00);
  endtask
  task automatic t_events();
    gpio_event <= 11'h7FF;
    uart_cdef_irq <= 4'hF;
    mouse_click_wake <= 1;
    @(posedge pclk);
    {gpio_event, uart_cdef_irq, mouse_click_wake} <= 16'h0;
    settle();
    rd_chk(8'h58, 32'hFE);
    rd_chk(8'h5C, 32'hFF);
    rd_chk(8'h54, 32'h10);
    wr(8'h58, 32'h00);
    rd_chk(8'h58, 32'hFE);
    wr(8'h58, 32'hFE);
    wr(8'h5C, 32'hFF);
    wr(8'h54, 32'h10);
    rd_chk(8'h58, 32'h00);
    rd_chk(8'h5C, 32'h00);
    rd_chk(8'h54, 32'h00);
  endtask
  task automatic t_irq_pin();
    gpio_event <= 11'h001;
    @(posedge pclk);
    gpio_event <= 11'h000;
    wr(8'h68, 32'h02);
    settle();
    chk({mgmt_irq_group, mgmt_interrupt_pin_n}, 2'b11);
    wr(8'h64, 32'h80);
    settle();
    chk({mgmt_irq_group, mgmt_interrupt_pin_n}, 2'b10);
    wr(8'h58, 32'h02);
    settle();
    chk({mgmt_irq_group, mgmt_interrupt_pin_n}, 2'b01);
  endtask
  task automatic t_unmapped();
    apb(0, 8'hFC, 32'h0, 4'hF);
    chk({err, rd}, {1'b1, 32'h0});
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_options();
    t_battery();
    t_parallel();
    t_sources();
    t_infrared();
    t_events();
    t_irq_pin();
    t_unmapped();
    end_of_test();
  end
endmodule // rs485_dir_and_smi_status_regs_tb_top
